// file: apsc_regs.sv
// Page-one amplifier power and short-circuit control registers.
// Assumes a byte register port on clk_i and asynchronous short detector levels.
//
// What this block does
// - Page register, eight bits, resets to zero
// - Headphone short clears power-up when short action is power down, unless kept
// - Speaker short clears power-up unless kept
// - Headphone top bit powers driver, resets off
// - Two-bit common-mode level field, resets 00
// - Short action: limit current or power down
// - Headphone status bit shows live short
// - Speaker top bit powers class-D driver
// - Speaker status bit shows live class-D short
`timescale 1ns/100ps
module apsc_regs
  import apsc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Register port
  input  wire apsc_req_t  req_i,
  input  wire logic       req_valid_i,
  output logic [7:0]      rdata_o,
  // Analog detectors and controls
  input  wire logic       hp_short_i,
  input  wire logic       spk_short_i,
  output apsc_drv_t       drv_o,
  output logic [7:0]      page_o
);

  // ---------------------------------------------------------------
  // Detector synchronisers
  // ---------------------------------------------------------------
  logic [1:0] hp_sync_r;
  logic [1:0] spk_sync_r;
  logic [1:0] hp_sync_nxt;
  logic [1:0] spk_sync_nxt;
  logic hp_short;
  logic spk_short;

  always_comb begin
    hp_sync_nxt = {hp_sync_r[0], hp_short_i};
    spk_sync_nxt = {spk_sync_r[0], spk_short_i};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hp_sync_r <= 2'h0;
      spk_sync_r <= 2'h0;
    end else if (ce_i) begin
      hp_sync_r <= hp_sync_nxt;
      spk_sync_r <= spk_sync_nxt;
    end
  end

  assign hp_short = hp_sync_r[1];
  assign spk_short = spk_sync_r[1];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] page, input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off) && ((off == APSC_OFF_PAGE) || (page == APSC_PAGE_ONE));
  endfunction

  logic [7:0] page_r;
  logic [7:0] policy_r;
  logic [7:0] hp_r;
  logic [7:0] spk_r;
  logic [7:0] page_nxt;
  logic [7:0] policy_nxt;
  logic [7:0] hp_nxt;
  logic [7:0] spk_nxt;
  logic wr;
  logic rsvd_hit;
  logic [7:0] rsvd_rdata;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rsvd_sel_r;
  logic rsvd_sel_nxt;

  assign wr = req_valid_i && req_i.wr;
  assign rsvd_hit = (page_r == APSC_PAGE_ONE) && (req_i.addr >= APSC_OFF_RSVD_LO)
                    && (req_i.addr <= APSC_OFF_RSVD_HI);

  // ---------------------------------------------------------------
  // Register next state
  // ---------------------------------------------------------------
  always_comb begin
    page_nxt = page_r;
    policy_nxt = policy_r;
    hp_nxt = hp_r;
    spk_nxt = spk_r;
    if (wr && hit(page_r, req_i.addr, APSC_OFF_PAGE)) begin
      page_nxt = req_i.wdata;
    end
    if (wr && hit(page_r, req_i.addr, APSC_OFF_POLICY)) begin
      policy_nxt = req_i.wdata;
    end
    if (wr && hit(page_r, req_i.addr, APSC_OFF_HP)) begin
      hp_nxt = (req_i.wdata & APSC_WMASK_HP) | (hp_r & ~APSC_WMASK_HP);
    end
    if (wr && hit(page_r, req_i.addr, APSC_OFF_SPK)) begin
      spk_nxt = (req_i.wdata & APSC_WMASK_SPK) | (spk_r & ~APSC_WMASK_SPK);
    end
    // Short clears win over a host write in the same cycle
    if (hp_short && !policy_r[APSC_POL_HP_KEEP] && hp_r[APSC_HP_PDN_SHORT]) begin
      hp_nxt[APSC_HP_PWR] = 1'b0;
    end
    if (spk_short && !policy_r[APSC_POL_SPK_KEEP]) begin
      spk_nxt[APSC_SPK_PWR] = 1'b0;
    end
    hp_nxt[APSC_HP_STAT] = hp_short;
    spk_nxt[APSC_SPK_STAT] = spk_short;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_r <= APSC_RST_PAGE;
      policy_r <= APSC_RST_POLICY;
      hp_r <= APSC_RST_HP;
      spk_r <= APSC_RST_SPK;
    end else if (ce_i) begin
      page_r <= page_nxt;
      policy_r <= policy_nxt;
      hp_r <= hp_nxt;
      spk_r <= spk_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Reserved locations
  // ---------------------------------------------------------------
  apsc_rsvd_mem u_rsvd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wr && rsvd_hit),
    .idx_i(5'(req_i.addr - APSC_OFF_RSVD_LO)),
    .wdata_i(req_i.wdata),
    .rdata_o(rsvd_rdata)
  );

  // ---------------------------------------------------------------
  // Read data, one cycle after the request
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    rsvd_sel_nxt = 1'b0;
    if (req_valid_i && !req_i.wr) begin
      if (hit(page_r, req_i.addr, APSC_OFF_PAGE)) begin
        rdata_nxt = page_r;
      end else if (hit(page_r, req_i.addr, APSC_OFF_POLICY)) begin
        rdata_nxt = policy_r;
      end else if (hit(page_r, req_i.addr, APSC_OFF_HP)) begin
        rdata_nxt = hp_r;
      end else if (hit(page_r, req_i.addr, APSC_OFF_SPK)) begin
        rdata_nxt = spk_r;
      end else if (rsvd_hit) begin
        rsvd_sel_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      rsvd_sel_r <= 1'b0;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
      rsvd_sel_r <= rsvd_sel_nxt;
    end
  end

  assign rdata_o = rsvd_sel_r ? rsvd_rdata : rdata_r;

  // ---------------------------------------------------------------
  // Driver controls
  // ---------------------------------------------------------------
  always_comb begin
    drv_o.hp_power = hp_r[APSC_HP_PWR];
    drv_o.hp_cm_level = hp_r[APSC_HP_CM_HI:APSC_HP_CM_LO];
    drv_o.hp_limit = hp_r[APSC_HP_STAT] && !hp_r[APSC_HP_PDN_SHORT];
    drv_o.hp_short_pdn = hp_r[APSC_HP_STAT] && hp_r[APSC_HP_PDN_SHORT];
    drv_o.spk_power = spk_r[APSC_SPK_PWR];
  end

  assign page_o = page_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hp_short_seen;
    ce_i && hp_short_i ##1 ce_i && 1'b1 ##1 ce_i;
  endsequence

  a_page_write_holds: assert property (ce_i && wr && req_i.addr == APSC_OFF_PAGE |=>
    page_r == $past(req_i.wdata)) else $error("page write lost");
  a_hp_short_clears: assert property (ce_i && hp_short && !policy_r[APSC_POL_HP_KEEP]
    && hp_r[APSC_HP_PDN_SHORT] |=> !hp_r[APSC_HP_PWR]) else $error("hp not cleared");
  a_hp_keep_power: assert property (ce_i && policy_r[APSC_POL_HP_KEEP] && hp_r[APSC_HP_PWR]
    && !wr |=> hp_r[APSC_HP_PWR]) else $error("hp power lost");
  a_spk_short_clears: assert property (ce_i && spk_short && !policy_r[APSC_POL_SPK_KEEP]
    |=> !spk_r[APSC_SPK_PWR]) else $error("spk not cleared");
  a_hp_status_sync: assert property (s_hp_short_seen |=> hp_r[APSC_HP_STAT])
    else $error("hp status late");
  a_spk_status_live: assert property (ce_i |=> spk_r[APSC_SPK_STAT] == $past(spk_short))
    else $error("spk status wrong");
  a_cm_level_out: assert property (ce_i && wr && page_r == APSC_PAGE_ONE
    && req_i.addr == APSC_OFF_HP
    |=> drv_o.hp_cm_level == $past(req_i.wdata[APSC_HP_CM_HI:APSC_HP_CM_LO]))
    else $error("cm level mismatch");
  a_short_action: assert property (ce_i && hp_short
    |=> drv_o.hp_short_pdn == hp_r[APSC_HP_PDN_SHORT]
    && drv_o.hp_limit == !hp_r[APSC_HP_PDN_SHORT])
    else $error("short action wrong");
  a_spk_power_out: assert property (ce_i && wr && page_r == APSC_PAGE_ONE
    && req_i.addr == APSC_OFF_SPK && !spk_short |=> drv_o.spk_power == $past(req_i.wdata[7]))
    else $error("spk power write");

endmodule

// file: apsc_pkg.sv
// Package for the page-one amplifier power and short-circuit register bank.
// Assumes a byte-wide register port driven by the codec's control-bus front end.
package apsc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] APSC_OFF_PAGE = 8'h00;
  localparam logic [7:0] APSC_OFF_RSVD_LO = 8'h01;
  localparam logic [7:0] APSC_OFF_RSVD_HI = 8'h1D;
  localparam logic [7:0] APSC_OFF_POLICY = 8'h1E;
  localparam logic [7:0] APSC_OFF_HP = 8'h1F;
  localparam logic [7:0] APSC_OFF_SPK = 8'h20;
  localparam logic [7:0] APSC_PAGE_ONE = 8'h01;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int APSC_POL_HP_KEEP = 1;
  localparam int APSC_POL_SPK_KEEP = 0;
  localparam int APSC_HP_PWR = 7;
  localparam int APSC_HP_CM_HI = 4;
  localparam int APSC_HP_CM_LO = 3;
  localparam int APSC_HP_PDN_SHORT = 1;
  localparam int APSC_HP_STAT = 0;
  localparam int APSC_SPK_PWR = 7;
  localparam int APSC_SPK_STAT = 0;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] APSC_RST_PAGE = 8'h00;
  localparam logic [7:0] APSC_RST_POLICY = 8'h00;
  localparam logic [7:0] APSC_RST_HP = 8'h04;
  localparam logic [7:0] APSC_RST_SPK = 8'h06;
  localparam logic [7:0] APSC_RST_RSVD = 8'h00;
  localparam logic [7:0] APSC_WMASK_HP = 8'hFE;
  localparam logic [7:0] APSC_WMASK_SPK = 8'hFE;
  localparam int APSC_RSVD_DEPTH = 29;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } apsc_req_t;

  // Driver controls towards the analog side
  typedef struct packed {
    logic       hp_power;
    logic [1:0] hp_cm_level;
    logic       hp_limit;
    logic       hp_short_pdn;
    logic       spk_power;
  } apsc_drv_t;

endpackage

// file: apsc_rsvd_mem.sv
// Small memory holding the reserved page-one locations.
// Assumes same-clock access; read data comes out of a register.
`timescale 1ns/100ps
module apsc_rsvd_mem
  import apsc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Access
  input  wire logic       we_i,
  input  wire logic [4:0] idx_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o
);

  logic [7:0] mem_r [APSC_RSVD_DEPTH];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (32'(idx_i) < APSC_RSVD_DEPTH) begin
      rdata_nxt = mem_r[idx_i];
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < APSC_RSVD_DEPTH; g++) begin : g_word
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          mem_r[g] <= APSC_RST_RSVD;
        end else if (ce_i && we_i && (32'(idx_i) == g)) begin
          mem_r[g] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= APSC_RST_RSVD;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

endmodule

// file: apsc_short_src.sv
// Model of the analog short detectors beside the amplifier bank.
// Assumes level commands from the bench; outputs move off the clock grid.
`timescale 1ns/100ps
module apsc_short_src (
  // Commands
  input  wire logic hp_cmd_i,
  input  wire logic spk_cmd_i,
  // Detector levels
  output wire logic hp_short_o,
  output wire logic spk_short_o
);
  // Unrelated detector delays
  assign #13 hp_short_o = hp_cmd_i;
  assign #17 spk_short_o = spk_cmd_i;
endmodule

// file: test_amp_power_short_control.sv
// Self-checking bench for the page-one amplifier register bank.
// Assumes apsc_pkg, apsc_regs and apsc_short_src compiled first.
`timescale 1ns/100ps
module test_amp_power_short_control;
  import apsc_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  apsc_req_t req_i = '0;
  logic req_valid_i = 1'b0;
  logic [7:0] rdata_o;
  logic [7:0] page_o;
  apsc_drv_t drv_o;
  logic hp_cmd = 1'b0;
  logic spk_cmd = 1'b0;
  wire hp_short;
  wire spk_short;
  logic rd_taken = 1'b0;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'hF1AF;
  logic [7:0] v;
  logic [7:0] h;
  logic d;
  logic hpw;
  logic spw;
  apsc_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .rdata_o(rdata_o), .hp_short_i(hp_short),
    .spk_short_i(spk_short), .drv_o(drv_o), .page_o(page_o));
  apsc_short_src i_src (.hp_cmd_i(hp_cmd), .spk_cmd_i(spk_cmd), .hp_short_o(hp_short),
    .spk_short_o(spk_short));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{wr: w, addr: a, wdata: dat};
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic drv(input logic [5:0] e);
    chk("drv", {2'h0, e}, {2'h0, drv_o});
  endtask
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Read monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    rd_taken <= req_valid_i & ~req_i.wr & ce_i & ~rst_i;
  end
  always @(negedge clk_i) begin
    if (rd_taken) begin
      chk("rdata", exp_q.pop_front(), rdata_o);
    end
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("page", 8'h00, page_o);
    drv(6'h00);
    v = 8'($random(seed));
    acc(1'b1, APSC_OFF_PAGE, v);
    chk("page", v, page_o);
    rd(APSC_OFF_PAGE, v);
    acc(1'b1, APSC_OFF_PAGE, APSC_PAGE_ONE);
    rd(APSC_OFF_POLICY, 8'h00);
    rd(APSC_OFF_HP, 8'h04);
    rd(APSC_OFF_SPK, 8'h06);
    rd(APSC_OFF_RSVD_HI, APSC_RST_RSVD);
    $display("test reset and page done");
    for (int i = 0; i < 4; i++) begin
      h = 8'h85 | 8'(i << 3);
      acc(1'b1, APSC_OFF_HP, h);
      drv({1'b1, 2'(i), 3'b000});
      rd(APSC_OFF_HP, h & 8'hFE);
    end
    acc(1'b1, APSC_OFF_SPK, 8'h87);
    drv(6'h39);
    rd(APSC_OFF_SPK, 8'h86);
    $display("test level and power done");
    for (int k = 0; k < 8; k++) begin
      d = (k >= 4);
      h = d ? 8'h86 : 8'h84;
      hpw = !(k[1] == 1'b0 && d);
      spw = k[0];
      acc(1'b1, APSC_OFF_POLICY, 8'(k & 3));
      acc(1'b1, APSC_OFF_HP, h);
      acc(1'b1, APSC_OFF_SPK, 8'h86);
      @(posedge clk_i);
      hp_cmd <= 1'b1;
      spk_cmd <= 1'b1;
      repeat (6) @(negedge clk_i);
      drv({hpw, 2'b00, ~d, d, spw});
      rd(APSC_OFF_HP, {hpw, h[6:1], 1'b1});
      rd(APSC_OFF_SPK, {spw, 7'h07});
      @(posedge clk_i);
      hp_cmd <= 1'b0;
      spk_cmd <= 1'b0;
      repeat (6) @(negedge clk_i);
      drv({hpw, 4'h0, spw});
      rd(APSC_OFF_HP, {hpw, h[6:1], 1'b0});
    end
    $display("test short policy done");
    @(posedge clk_i);
    ce_i <= 1'b0;
    acc(1'b1, APSC_OFF_PAGE, 8'h5A);
    @(posedge clk_i);
    ce_i <= 1'b1;
    @(negedge clk_i);
    chk("page", APSC_PAGE_ONE, page_o);
    $display("test clock enable done");
    finish_test();
  end
endmodule
